// File: dmc_chan_model.sv
module dmc_chan_model (
  input  wire logic        core_clk_i, // Clock
  input  wire logic        rst_n_i,    // Synchronous reset, active low
  input  wire logic        push_i,     // Offer double words while high
  input  wire logic        pop_i,      // Take double words while high
  input  wire logic        wr_ready_i, // FIFO has room
  output logic             wr_valid_o, // Write request
  output logic      [63:0] wr_data_o,  // Double word offered
  output logic             rd_ready_o, // Read request, low to stall
  output logic      [6:0]  pushed_o    // Words accepted so far
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] next_pushed;
  always_comb begin
    next_pushed = pushed_o;
    if (wr_valid_o && wr_ready_i) begin
      next_pushed = pushed_o + 7'h01;
    end
  end
  always_ff @(posedge core_clk_i) begin
    pushed_o <= rst_n_i ? next_pushed : 7'h00;
  end
  assign wr_valid_o = push_i;
  // Word k carries k in its low bits; idle data is inverted so stale values never pass
  assign wr_data_o  = push_i ? (64'ha5a5_0000_0000_0000 + 64'(pushed_o)) : ~(64'ha5a5_0000_0000_0000 + 64'(pushed_o));
  assign rd_ready_o = pop_i;
endmodule

// File: dmc_fifo_mem.sv
module dmc_fifo_mem
  import dmc_pkg::*;
#(
  parameter int unsigned WIDTH = DMC_FIFO_WIDTH,
  parameter int unsigned DEPTH = DMC_FIFO_DEPTH,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             core_clk_i, // Clock
  input  wire logic             we_i,       // Write strobe
  input  wire logic [AW-1:0]    waddr_i,    // Write slot
  input  wire logic [WIDTH-1:0] wdata_i,    // Write data
  input  wire logic [AW-1:0]    raddr_i,    // Slot to show next cycle
  output logic      [WIDTH-1:0] rdata_o     // Registered read data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  always_comb begin
    next_rdata = mem[raddr_i];
    if (we_i && (waddr_i == raddr_i)) begin
      next_rdata = wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= next_rdata;
  end
endmodule

// File: dmc_master_ctrl.sv
// What this block does
// - Bits 31:28 read back a per-channel pending error interrupt flag, bit n for channel n.
// - Bits 27:24 read back a per-channel completion flag, set when a transfer or chain ends.
// - Bits 20:14 read back the number of bytes written into the FIFO and not yet read.
// - Bits 13:11 read back the FIFO slot that takes the next write.
// - Bits 10:8 read back the FIFO slot that supplies the next read.
// - While bit 7 is one the FIFO pointers and byte count are held at zero.
// - Bits 6:3 are writable enables telling each channel to pass dual address data through the FIFO.
// - With bit 1 set, arbitration rotates so the last served channel has the lowest priority.
// - With bit 1 clear, channel 0 has the highest priority and channel 3 the lowest.
// - The controller works only while bit 0 is one, and bit 0 resets to zero.
// - Reset clears every field of the register to zero.
// - A channel error or completion event sets that channel's bit in the matching flag group.
module dmc_master_ctrl
  import dmc_pkg::*;
#(
  parameter int unsigned NCH = DMC_CHANNELS
) (
  input  wire logic                      core_clk_i,       // 50 MHz clock
  input  wire logic                      rst_n_i,          // Synchronous reset, active low
  input  wire logic                      psel,             // APB select
  input  wire logic                      penable,          // APB access phase
  input  wire logic                      pwrite,           // APB direction
  input  wire logic [15:0]               paddr,            // APB byte address
  input  wire logic [31:0]               pwdata,           // APB write data
  output logic                           pready,           // APB ready
  output logic      [31:0]               prdata,           // APB read data
  output logic                           pslverr,          // APB error, unmapped address
  input  wire logic [NCH-1:0]            ch_err_evt_i,     // Channel error event pulses
  input  wire logic [NCH-1:0]            ch_done_evt_i,    // Channel completion event pulses
  input  wire logic [NCH-1:0]            ch_req_i,         // Channel bus requests
  input  wire logic                      arb_take_i,       // Granted channel starts its transfer
  output logic      [NCH-1:0]            ch_grant_o,       // One-hot grant
  output logic      [NCH-1:0]            channel_fifo_use_o, // Per-channel FIFO use enables
  output logic                           controller_enable_o, // Controller enabled
  input  wire logic                      fifo_wr_valid_i,  // FIFO write request
  output logic                           fifo_wr_ready_o,  // FIFO has room
  input  wire logic [DMC_FIFO_WIDTH-1:0] fifo_wr_data_i,   // Double word to write
  output logic                           fifo_rd_valid_o,  // FIFO holds data
  input  wire logic                      fifo_rd_ready_i,  // FIFO read request
  output logic      [DMC_FIFO_WIDTH-1:0] fifo_rd_data_o,   // Double word at the read slot
  output logic                           irq_o             // Level interrupt
);
  logic [NCH-1:0] channel_error_irq_flags, next_err;
  logic [NCH-1:0] channel_done_irq_flags, next_done;
  logic [6:0]     fifo_valid_byte_count, next_count;
  logic [2:0]     fifo_write_slot, next_wslot;
  logic [2:0]     fifo_read_slot, next_rslot;
  logic           fifo_clear, next_clear;
  logic [NCH-1:0] channel_fifo_use, next_use;
  logic           rotating_priority_select, next_rr;
  logic           controller_enable, next_en;
  logic [7:0]     irq_mask, next_mask;
  logic [1:0]     last_served, next_last;
  logic [31:0]    next_prdata;
  logic           next_slverr;
  logic           ctrl_rst;
  logic           setup, wr_acc;
  logic           push, pop;
  logic [1:0]     grant_idx;
  logic           grant_any;

  // Index of the first requester found walking upward from start
  function automatic logic [2:0] pick(input logic [NCH-1:0] req, input logic [1:0] start);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'b000;
    for (int i = NCH - 1; i >= 0; i--) begin
      idx = 2'(start + 2'(i));
      if (req[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] decode_read(input logic [15:0] a, input logic [31:0] glob,
                                              input logic [7:0] st, input logic [7:0] mk);
    case (a)
      DMC_GLOBAL_LO:  decode_read = glob;
      DMC_IRQ_STATUS: decode_read = {24'h000000, st};
      DMC_IRQ_MASK:   decode_read = {24'h000000, mk};
      default:        decode_read = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [15:0] a);
    mapped = (a == DMC_GLOBAL_LO) || (a == DMC_GLOBAL_HI) || (a == DMC_IRQ_STATUS) || (a == DMC_IRQ_MASK);
  endfunction

  assign ctrl_rst = !rst_n_i || !controller_enable;
  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && mapped(paddr);
  assign pready   = 1'b1;

  assign fifo_wr_ready_o = controller_enable && !fifo_clear && (fifo_valid_byte_count != DMC_CNT_FULL);
  assign fifo_rd_valid_o = controller_enable && !fifo_clear && (fifo_valid_byte_count != DMC_CNT_RST);
  assign push = fifo_wr_valid_i && fifo_wr_ready_o;
  assign pop  = fifo_rd_valid_o && fifo_rd_ready_i;

  assign {grant_any, grant_idx} = pick(ch_req_i, rotating_priority_select ? 2'(last_served + 2'd1) : 2'd0);
  assign ch_grant_o = (controller_enable && grant_any) ? (NCH'(1) << grant_idx) : '0;
  assign channel_fifo_use_o  = channel_fifo_use;
  assign controller_enable_o = controller_enable;
  assign irq_o = |({channel_error_irq_flags, channel_done_irq_flags} & irq_mask);

  // Software-owned control fields
  always_comb begin
    next_clear = fifo_clear;
    next_use   = channel_fifo_use;
    next_rr    = rotating_priority_select;
    next_en    = controller_enable;
    next_mask  = irq_mask;
    if (wr_acc && paddr == DMC_GLOBAL_LO) begin
      next_clear = pwdata[DMC_CLR_BIT];
      next_use   = pwdata[DMC_USE_MSB:DMC_USE_LSB];
      next_rr    = pwdata[DMC_RR_BIT];
      next_en    = pwdata[DMC_EN_BIT];
    end
    if (wr_acc && paddr == DMC_IRQ_MASK) begin
      next_mask = pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fifo_clear               <= 1'b0;
      channel_fifo_use         <= DMC_USE_RST;
      rotating_priority_select <= 1'b0;
      controller_enable        <= 1'b0;
      irq_mask                 <= DMC_MASK_RST;
    end else begin
      fifo_clear               <= next_clear;
      channel_fifo_use         <= next_use;
      rotating_priority_select <= next_rr;
      controller_enable        <= next_en;
      irq_mask                 <= next_mask;
    end
  end

  // Sticky flags: a new event wins over a write-one clear
  always_comb begin
    next_err  = channel_error_irq_flags;
    next_done = channel_done_irq_flags;
    if (wr_acc && paddr == DMC_IRQ_STATUS) begin
      next_err  = next_err & ~pwdata[7:4];
      next_done = next_done & ~pwdata[3:0];
    end
    next_err  = next_err | ch_err_evt_i;
    next_done = next_done | ch_done_evt_i;
  end

  // FIFO bookkeeping and arbitration history
  always_comb begin
    next_wslot = fifo_write_slot;
    next_rslot = fifo_read_slot;
    next_count = fifo_valid_byte_count;
    next_last  = last_served;
    if (push) begin
      next_wslot = 3'(fifo_write_slot + 3'd1);
      next_count = 7'(next_count + DMC_SLOT_INC);
    end
    if (pop) begin
      next_rslot = 3'(fifo_read_slot + 3'd1);
      next_count = 7'(next_count - DMC_SLOT_INC);
    end
    if (fifo_clear) begin
      next_wslot = DMC_PTR_RST;
      next_rslot = DMC_PTR_RST;
      next_count = DMC_CNT_RST;
    end
    if (arb_take_i && |ch_grant_o) begin
      next_last = grant_idx;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (ctrl_rst) begin
      channel_error_irq_flags <= DMC_FLAGS_RST;
      channel_done_irq_flags  <= DMC_FLAGS_RST;
      fifo_write_slot         <= DMC_PTR_RST;
      fifo_read_slot          <= DMC_PTR_RST;
      fifo_valid_byte_count   <= DMC_CNT_RST;
      last_served             <= 2'd3;
    end else begin
      channel_error_irq_flags <= next_err;
      channel_done_irq_flags  <= next_done;
      fifo_write_slot         <= next_wslot;
      fifo_read_slot          <= next_rslot;
      fifo_valid_byte_count   <= next_count;
      last_served             <= next_last;
    end
  end

  // Read data is captured in the setup cycle and shown during the access phase
  always_comb begin
    next_prdata = prdata;
    next_slverr = pslverr;
    if (setup) begin
      next_prdata = decode_read(paddr,
                      {channel_error_irq_flags, channel_done_irq_flags, 3'b000,
                       fifo_valid_byte_count, fifo_write_slot, fifo_read_slot,
                       fifo_clear, channel_fifo_use, 1'b0, rotating_priority_select, controller_enable},
                      {channel_error_irq_flags, channel_done_irq_flags}, irq_mask);
      next_slverr = !mapped(paddr);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_slverr;
    end
  end

  dmc_fifo_mem u_mem (
    .core_clk_i (core_clk_i),
    .we_i       (push),
    .waddr_i    (fifo_write_slot),
    .wdata_i    (fifo_wr_data_i),
    .raddr_i    (next_rslot),
    .rdata_o    (fifo_rd_data_o)
  );

  property p_err_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    setup && !pwrite && paddr == DMC_GLOBAL_LO |=> prdata[31:28] == $past(channel_error_irq_flags);
  endproperty
  a_err_read: assert property (p_err_read) else $error("error flags misread");

  property p_done_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    setup && !pwrite && paddr == DMC_GLOBAL_LO |=> prdata[27:24] == $past(channel_done_irq_flags);
  endproperty
  a_done_read: assert property (p_done_read) else $error("done flags misread");

  property p_count_up;
    @(posedge core_clk_i) disable iff (ctrl_rst)
    push && !pop && !fifo_clear |=> fifo_valid_byte_count == 7'($past(fifo_valid_byte_count) + 7'd8);
  endproperty
  a_count_up: assert property (p_count_up) else $error("byte count not raised by eight");

  property p_wslot;
    @(posedge core_clk_i) disable iff (ctrl_rst)
    push && !fifo_clear |=> fifo_write_slot == 3'($past(fifo_write_slot) + 3'd1);
  endproperty
  a_wslot: assert property (p_wslot) else $error("write slot not advanced");

  property p_rslot;
    @(posedge core_clk_i) disable iff (ctrl_rst)
    pop && !fifo_clear |=> fifo_read_slot == 3'($past(fifo_read_slot) + 3'd1);
  endproperty
  a_rslot: assert property (p_rslot) else $error("read slot not advanced");

  property p_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    fifo_clear |=> fifo_valid_byte_count == 7'h00 && fifo_write_slot == 3'h0 && fifo_read_slot == 3'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("fifo not cleared");

  property p_use_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_acc && paddr == DMC_GLOBAL_LO |=> channel_fifo_use_o == $past(pwdata[6:3]);
  endproperty
  a_use_write: assert property (p_use_write) else $error("fifo use enables not written");

  property p_rotate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    controller_enable && rotating_priority_select && last_served == 2'd0 && ch_req_i == 4'hf
      |-> ch_grant_o == 4'h2;
  endproperty
  a_rotate: assert property (p_rotate) else $error("round robin order wrong");

  property p_fixed;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    controller_enable && !rotating_priority_select && ch_req_i[0] |-> ch_grant_o == 4'h1;
  endproperty
  a_fixed: assert property (p_fixed) else $error("channel 0 not highest");

  property p_disabled;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !controller_enable |=> ch_grant_o == 4'h0 || $past(next_en);
  endproperty
  a_disabled: assert property (p_disabled) else $error("grant while disabled");

  property p_hold_reset;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !controller_enable ##1 !controller_enable |-> fifo_valid_byte_count == 7'h00 && channel_error_irq_flags == 4'h0;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("logic not held in reset");

  property p_reset;
    @(posedge core_clk_i) !rst_n_i |=> controller_enable == 1'b0 && channel_fifo_use == 4'h0 && !fifo_clear;
  endproperty
  a_reset: assert property (p_reset) else $error("fields not cleared by reset");

  property p_event;
    @(posedge core_clk_i) disable iff (ctrl_rst)
    ch_err_evt_i[2] |=> channel_error_irq_flags[2];
  endproperty
  a_event: assert property (p_event) else $error("error event lost");

  property p_high_zero;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    setup && paddr == DMC_GLOBAL_HI |=> prdata == 32'h00000000;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("reserved word not zero");

  c_fifo_full: cover property (@(posedge core_clk_i) fifo_valid_byte_count == DMC_CNT_FULL);
  c_rr_grant:  cover property (@(posedge core_clk_i) rotating_priority_select && arb_take_i && ch_grant_o == 4'h8);
  c_irq:       cover property (@(posedge core_clk_i) irq_o);
endmodule

// File: dmc_pkg.sv
package dmc_pkg;
  localparam int unsigned DMC_CHANNELS     = 4;
  localparam int unsigned DMC_FIFO_DEPTH   = 8;
  localparam int unsigned DMC_FIFO_WIDTH   = 64;
  localparam int unsigned DMC_SLOT_BYTES   = 8;
  localparam int unsigned DMC_CLK_MHZ      = 50;

  localparam logic [15:0] DMC_GLOBAL_LO    = 16'hb150;
  localparam logic [15:0] DMC_GLOBAL_HI    = 16'hb154;
  localparam logic [15:0] DMC_IRQ_STATUS   = 16'hb160;
  localparam logic [15:0] DMC_IRQ_MASK     = 16'hb164;

  localparam int unsigned DMC_ERR_MSB      = 31;
  localparam int unsigned DMC_ERR_LSB      = 28;
  localparam int unsigned DMC_DONE_MSB     = 27;
  localparam int unsigned DMC_DONE_LSB     = 24;
  localparam int unsigned DMC_CNT_MSB      = 20;
  localparam int unsigned DMC_CNT_LSB      = 14;
  localparam int unsigned DMC_WP_MSB       = 13;
  localparam int unsigned DMC_WP_LSB       = 11;
  localparam int unsigned DMC_RP_MSB       = 10;
  localparam int unsigned DMC_RP_LSB       = 8;
  localparam int unsigned DMC_CLR_BIT      = 7;
  localparam int unsigned DMC_USE_MSB      = 6;
  localparam int unsigned DMC_USE_LSB      = 3;
  localparam int unsigned DMC_RR_BIT       = 1;
  localparam int unsigned DMC_EN_BIT       = 0;

  localparam logic [3:0]  DMC_FLAGS_RST    = 4'h0;
  localparam logic [6:0]  DMC_CNT_RST      = 7'h00;
  localparam logic [2:0]  DMC_PTR_RST      = 3'h0;
  localparam logic [3:0]  DMC_USE_RST      = 4'h0;
  localparam logic [7:0]  DMC_MASK_RST     = 8'h00;
  localparam logic [6:0]  DMC_SLOT_INC     = 7'h08;
  localparam logic [6:0]  DMC_CNT_FULL     = 7'h40;
endpackage

// File: tb_dma_master_control.sv
module tb_dma_master_control;
  timeunit 1ns;
  timeprecision 1ns;
  import dmc_pkg::*;
  logic        core_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, er, push, pop;
  logic        arb_take_i, fifo_wr_valid_i, fifo_wr_ready_o, fifo_rd_valid_o, fifo_rd_ready_i;
  logic        controller_enable_o, irq_o;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  ch_err_evt_i, ch_done_evt_i, ch_req_i, ch_grant_o, channel_fifo_use_o;
  logic [63:0] fifo_wr_data_i, fifo_rd_data_o;
  logic [6:0]  pushed, b;
  int          error_cnt, cmp_count, cyc;
  localparam logic [63:0] WB = 64'ha5a5_0000_0000_0000;

  dmc_master_ctrl dut (.core_clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .ch_err_evt_i, .ch_done_evt_i, .ch_req_i, .arb_take_i, .ch_grant_o, .channel_fifo_use_o,
    .controller_enable_o, .fifo_wr_valid_i, .fifo_wr_ready_o, .fifo_wr_data_i, .fifo_rd_valid_o,
    .fifo_rd_ready_i, .fifo_rd_data_o, .irq_o);
  dmc_chan_model peer (.core_clk_i, .rst_n_i, .push_i(push), .pop_i(pop), .wr_ready_i(fifo_wr_ready_o),
    .wr_valid_o(fifo_wr_valid_i), .wr_data_o(fifo_wr_data_i), .rd_ready_o(fifo_rd_ready_i), .pushed_o(pushed));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("Error at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered right after a rising edge; leaves one idle edge so the next setup never collides
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(64'(rd), 64'(exp));
  endtask

  function automatic logic [31:0] gw(input logic [3:0] e, input logic [3:0] dn, input logic [6:0] c,
                                     input logic [2:0] w, input logic [2:0] r, input logic [7:0] ct);
    return {e, dn, 3'h0, c, w, r, ct};
  endfunction

  task automatic pulse(input logic [3:0] e, input logic [3:0] dn);
    ch_err_evt_i <= e;
    ch_done_evt_i <= dn;
    @(posedge core_clk_i);
    ch_err_evt_i <= 4'h0;
    ch_done_evt_i <= 4'h0;
    @(posedge core_clk_i);
  endtask

  task automatic t_reset();
    rdchk(DMC_GLOBAL_LO, 32'h0);
    rdchk(DMC_GLOBAL_HI, 32'h0);
    rdchk(DMC_IRQ_MASK, 32'h0);
    chk(64'(controller_enable_o), 64'h0);
    chk(64'(irq_o), 64'h0);
    $display("Test reset finished");
  endtask

  task automatic t_ctrl();
    apb(1'b1, DMC_GLOBAL_LO, 32'hffff_ffff);
    rdchk(DMC_GLOBAL_LO, gw(4'h0, 4'h0, 7'h00, 3'h0, 3'h0, 8'hfb));
    chk(64'(channel_fifo_use_o), 64'hf);
    chk(64'(controller_enable_o), 64'h1);
    apb(1'b1, DMC_GLOBAL_HI, 32'hffff_ffff);
    rdchk(DMC_GLOBAL_HI, 32'h0);
    apb(1'b1, DMC_GLOBAL_LO, 32'h0000_0029);
    chk(64'(channel_fifo_use_o), 64'h5);
    $display("Test control finished");
  endtask

  task automatic t_fifo();
    b = pushed;
    push <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    push <= 1'b0;
    @(posedge core_clk_i);
    rdchk(DMC_GLOBAL_LO, gw(4'h0, 4'h0, 7'd24, 3'd3, 3'd0, 8'h29));
    chk(fifo_rd_data_o, WB + 64'(b));
    pop <= 1'b1;
    @(posedge core_clk_i);
    pop <= 1'b0;
    @(posedge core_clk_i);
    rdchk(DMC_GLOBAL_LO, gw(4'h0, 4'h0, 7'd16, 3'd3, 3'd1, 8'h29));
    chk(fifo_rd_data_o, WB + 64'(b) + 64'h1);
    push <= 1'b1;
    repeat (7) @(posedge core_clk_i);
    push <= 1'b0;
    @(posedge core_clk_i);
    chk(64'(fifo_wr_ready_o), 64'h0);
    chk(64'(pushed - b), 64'd9);
    rdchk(DMC_GLOBAL_LO, gw(4'h0, 4'h0, 7'h40, 3'd1, 3'd1, 8'h29));
    pulse(4'h1, 4'h0);
    apb(1'b1, DMC_IRQ_STATUS, 32'h10);
    apb(1'b1, DMC_GLOBAL_LO, 32'h0000_00a9);
    rdchk(DMC_GLOBAL_LO, gw(4'h0, 4'h0, 7'h00, 3'd0, 3'd0, 8'ha9));
    chk(64'(fifo_rd_valid_o), 64'h0);
    apb(1'b1, DMC_GLOBAL_LO, 32'h0000_0029);
    $display("Test fifo finished");
  endtask

  task automatic t_irq();
    pulse(4'h4, 4'h2);
    rdchk(DMC_GLOBAL_LO, gw(4'h4, 4'h2, 7'h00, 3'd0, 3'd0, 8'h29));
    rdchk(DMC_IRQ_STATUS, 32'h42);
    chk(64'(irq_o), 64'h0);
    apb(1'b1, DMC_IRQ_MASK, 32'h40);
    chk(64'(irq_o), 64'h1);
    apb(1'b1, DMC_IRQ_STATUS, 32'h40);
    chk(64'(irq_o), 64'h0);
    rdchk(DMC_GLOBAL_LO, gw(4'h0, 4'h2, 7'h00, 3'd0, 3'd0, 8'h29));
    apb(1'b0, 16'hb200, 32'h0);
    chk(64'(er), 64'h1);
    chk(64'(rd), 64'h0);
    $display("Test interrupt finished");
  endtask

  task automatic take_and_check(input logic [3:0] exp);
    arb_take_i <= 1'b1;
    @(posedge core_clk_i);
    arb_take_i <= 1'b0;
    @(posedge core_clk_i);
    chk(64'(ch_grant_o), 64'(exp));
  endtask

  task automatic t_arb();
    ch_req_i <= 4'he;
    @(posedge core_clk_i);
    chk(64'(ch_grant_o), 64'h2);
    ch_req_i <= 4'hf;
    @(posedge core_clk_i);
    chk(64'(ch_grant_o), 64'h1);
    apb(1'b1, DMC_GLOBAL_LO, 32'h0000_002b);
    chk(64'(ch_grant_o), 64'h1);
    take_and_check(4'h2);
    take_and_check(4'h4);
    ch_req_i <= 4'h9;
    @(posedge core_clk_i);
    chk(64'(ch_grant_o), 64'h8);
    $display("Test arbitration finished");
  endtask

  task automatic t_dis();
    pulse(4'h1, 4'h8);
    apb(1'b1, DMC_GLOBAL_LO, 32'h0000_002a);
    ch_req_i <= 4'hf;
    pulse(4'h2, 4'h0);
    chk(64'(ch_grant_o), 64'h0);
    chk(64'(controller_enable_o), 64'h0);
    rdchk(DMC_GLOBAL_LO, gw(4'h0, 4'h0, 7'h00, 3'd0, 3'd0, 8'h2a));
    apb(1'b1, DMC_GLOBAL_LO, 32'h0000_002b);
    chk(64'(ch_grant_o), 64'h1);
    $display("Test disable finished");
  endtask

  initial begin
    {psel, penable, pwrite, push, pop, arb_take_i} = 6'h0;
    {paddr, pwdata, ch_err_evt_i, ch_done_evt_i, ch_req_i} = '0;
    rst_n_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_ctrl();
    t_fifo();
    t_irq();
    t_arb();
    t_dis();
    report_and_stop();
  end
endmodule
